// ===== common/wsr_consts.vh
// constants shared by the watchdog and soft reset supervisor
// assumes a 100 MHz sys_clk and one millisecond watchdog tick
`ifndef WSR_CONSTS_VH
`define WSR_CONSTS_VH

// ---------------------------------------------------------------
// command targets
// ---------------------------------------------------------------
`define WSR_ADDR_MODE 2'h0
`define WSR_ADDR_WAKE 2'h1
`define WSR_ADDR_CTRL 2'h2

// ---------------------------------------------------------------
// field positions and encodings
// ---------------------------------------------------------------
`define WSR_MODE_NORMAL  2'h0
`define WSR_MODE_SLEEP   2'h1
`define WSR_MODE_STOP    2'h2
`define WSR_MODE_SOFTRST 2'h3
`define WSR_MODE_SRO_BIT 2
`define WSR_WAKE_EN0_BIT 0
`define WSR_CTRL_RSV_BIT 3
`define WSR_CTRL_WIN_BIT 4
`define WSR_CTRL_EN1_BIT 5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define WSR_RST_PERIOD 3'h4
`define WSR_RST_WIN    1'b0
`define WSR_RST_SRO    1'b0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define WSR_CLK_MHZ         100
`define WSR_TICK_MS         1
`define WSR_TICK_CYCLES     (`WSR_TICK_MS * `WSR_CLK_MHZ * 1000)
`define WSR_LONG_WIN_MS     200
`define WSR_RESET_DELAY_MS  10
`define WSR_CLOSED_PCT      60

`endif

// ===== src/wsr_sync.v
// three stage synchroniser for pin level inputs
// assumes the inputs are asynchronous to sys_clk
`timescale 1ns/1ns
module wsr_sync #(
   parameter               WIDTH     = 2,
   parameter [WIDTH-1:0]   RESET_VAL = {WIDTH{1'b0}}
)(
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] pinIn,
   output reg  [WIDTH-1:0] levelOut
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;
   reg [WIDTH-1:0] stage3_reg;
   integer         i;

   // -------------------------------------------------------------
   // a bit only moves once stages two and three agree
   // -------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1_reg <= RESET_VAL;
         stage2_reg <= RESET_VAL;
         stage3_reg <= RESET_VAL;
         levelOut   <= RESET_VAL;
      end
      else
      begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         for (i = 0; i < WIDTH; i = i + 1)
            if (stage2_reg[i] == stage3_reg[i])
               levelOut[i] <= stage3_reg[i];
      end
   end

endmodule

// ===== src/wsr_watchdog.v
// watchdog supervisor with guarded stop disable and soft reset
// assumes an spi decoder on sys_clk presents complete writes; the chip
// select pin and development strap are asynchronous pins
`timescale 1ns/1ns
`include "wsr_consts.vh"
module wsr_watchdog #(
   parameter [23:0] TICK_CYCLES    = `WSR_TICK_CYCLES,
   parameter [10:0] LONG_WIN_MS    = `WSR_LONG_WIN_MS,
   parameter [10:0] RESET_DELAY_MS = `WSR_RESET_DELAY_MS
)(
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       chip_select_low_active,
   input  wire       devStrap,
   input  wire       cmdWrite,
   input  wire [1:0] cmdAddr,
   input  wire [7:0] cmdData,
   input  wire [1:0] failConfig,
   input  wire       wakeRequest,
   input  wire       spiFailClear,
   output reg        reset_out_n,
   output reg  [2:0] opMode,
   output reg  [1:0] failure_count,
   output reg        spiFail,
   output reg        window_type_select,
   output reg  [2:0] period_select,
   output reg        soft_reset_output_select,
   output reg        stop_disable_enable_first,
   output reg        stop_disable_enable_second,
   output reg        watchdogOff,
   output reg  [7:0] controlReadback
);

   // -------------------------------------------------------------
   // operating modes and watchdog phases
   // -------------------------------------------------------------
   localparam [2:0] M_INIT     = 3'h0;
   localparam [2:0] M_NORMAL   = 3'h1;
   localparam [2:0] M_STOP     = 3'h2;
   localparam [2:0] M_SLEEP    = 3'h3;
   localparam [2:0] M_RESTART  = 3'h4;
   localparam [2:0] M_FAILSAFE = 3'h5;
   localparam [1:0] PH_OFF     = 2'h0;
   localparam [1:0] PH_LONG    = 2'h1;
   localparam [1:0] PH_CLOSED  = 2'h2;
   localparam [1:0] PH_OPEN    = 2'h3;

   // -------------------------------------------------------------
   // period lookup and closed window width
   // -------------------------------------------------------------
   function [10:0] periodMs;
      input [2:0] sel;
      begin
         case (sel)
            3'h2:    periodMs = 11'h014;
            3'h3:    periodMs = 11'h032;
            3'h4:    periodMs = 11'h064;
            3'h5:    periodMs = 11'h0C8;
            3'h6:    periodMs = 11'h1F4;
            3'h7:    periodMs = 11'h3E8;
            default: periodMs = 11'h00A; // zero folds onto 10 ms
         endcase
      end
   endfunction

   function [10:0] closedMs;
      input [10:0] per;
      reg   [17:0] prod;
      begin
         prod     = ({7'h00, per} * 18'h0003C) / 18'h00064;
         closedMs = prod[10:0]; // at most 1228, fits eleven bits
      end
   endfunction

   // -------------------------------------------------------------
   // pin synchronisation
   // -------------------------------------------------------------
   wire [1:0] pinLevels;

   wsr_sync #(
      .WIDTH     (2),
      .RESET_VAL (2'b01)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .pinIn    ({devStrap, chip_select_low_active}),
      .levelOut (pinLevels)
   );

   wire csHigh  = pinLevels[0];
   wire devMode = pinLevels[1];

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   reg        csPrev_reg;
   reg        pendValid_reg;
   reg  [1:0] pendAddr_reg;
   reg  [7:0] pendData_reg;
   reg  [1:0] wdPhase_reg;
   reg [23:0] tickCnt_reg;
   reg [10:0] msCnt_reg;

   // -------------------------------------------------------------
   // command execution decode
   // -------------------------------------------------------------
   wire       exec     = pendValid_reg & csHigh & ~csPrev_reg;
   wire       wrMode   = exec & (pendAddr_reg == `WSR_ADDR_MODE);
   wire       wrWake   = exec & (pendAddr_reg == `WSR_ADDR_WAKE);
   wire       wrCtrl   = exec & (pendAddr_reg == `WSR_ADDR_CTRL);
   // reserved bit 3 takes part as written
   wire       parityOk = ~(^pendData_reg);
   wire       inNormal = (opMode == M_NORMAL);
   wire       inStop   = (opMode == M_STOP);
   wire       wdMode   = (opMode == M_INIT) | inNormal | inStop;
   wire       msTick   = (tickCnt_reg == TICK_CYCLES - 24'h000001);
   wire [10:0] perMs   = periodMs(period_select);
   wire [10:0] clsMs   = closedMs(perMs);
   wire       wdRun    = reset_out_n & wdMode & ~devMode &
                         (wdPhase_reg != PH_OFF);
   wire [10:0] limitMs = (wdPhase_reg == PH_LONG) ? LONG_WIN_MS : perMs;

   // expiry of long window or period with no good trigger
   wire wdExpire = wdRun & msTick & (wdPhase_reg != PH_CLOSED) &
                   (msCnt_reg == limitMs - 11'h001);
   wire trigValid = wrCtrl & parityOk & wdMode & reset_out_n;
   wire trigBad   = trigValid & wdRun &
                    (wdPhase_reg == PH_CLOSED);
   wire trigGood  = trigValid & ~trigBad;
   wire wdFail    = trigBad | wdExpire;
   wire softReset = wrMode & (pendData_reg[1:0] == `WSR_MODE_SOFTRST) &
                    (inNormal | inStop);
   wire [1:0] failMax = (failConfig == 2'h1) ? 2'h1 : 2'h2;

   // -------------------------------------------------------------
   // tick counter, restarted by a good trigger, soft reset, failure or its own wrap
   // -------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         tickCnt_reg <= 24'h000000;
      else if (trigGood | softReset | wdFail | msTick)
         tickCnt_reg <= 24'h000000;
      else
         tickCnt_reg <= tickCnt_reg + 24'h000001;
   end

   // -------------------------------------------------------------
   // command capture; the write only acts once chip select rises
   // -------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         csPrev_reg    <= 1'b1;
         pendValid_reg <= 1'b0;
         pendAddr_reg  <= 2'h0;
         pendData_reg  <= 8'h00;
      end
      else
      begin
         csPrev_reg <= csHigh;
         if (cmdWrite)
         begin
            pendValid_reg <= 1'b1;
            pendAddr_reg  <= cmdAddr;
            pendData_reg  <= cmdData;
         end
         else if (exec)
            pendValid_reg <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // spi failure flag; a new parity error wins over the clear
   // -------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         spiFail <= 1'b0;
      else if (wrCtrl & ~parityOk)
         spiFail <= 1'b1;
      else if (spiFailClear | softReset)
         spiFail <= 1'b0;
   end

   // -------------------------------------------------------------
   // mode, watchdog phase and configuration
   // -------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         opMode                     <= M_INIT;
         reset_out_n                <= 1'b0;
         wdPhase_reg                <= PH_OFF;
         msCnt_reg                  <= 11'h000;
         failure_count              <= 2'h0;
         window_type_select         <= `WSR_RST_WIN;
         period_select              <= `WSR_RST_PERIOD;
         soft_reset_output_select   <= `WSR_RST_SRO;
         stop_disable_enable_first  <= 1'b0;
         stop_disable_enable_second <= 1'b0;
         controlReadback            <= {3'h0, `WSR_RST_WIN, 1'b0,
                                        `WSR_RST_PERIOD};
      end
      else if (softReset)
      begin
         // everything back to defaults; output pulse is optional
         opMode                     <= M_INIT;
         msCnt_reg                  <= 11'h000;
         failure_count              <= 2'h0;
         window_type_select         <= `WSR_RST_WIN;
         period_select              <= `WSR_RST_PERIOD;
         soft_reset_output_select   <= `WSR_RST_SRO;
         stop_disable_enable_first  <= 1'b0;
         stop_disable_enable_second <= 1'b0;
         controlReadback            <= {3'h0, `WSR_RST_WIN, 1'b0,
                                        `WSR_RST_PERIOD};
         if (!soft_reset_output_select)
         begin
            reset_out_n <= 1'b0;
            wdPhase_reg <= PH_OFF;
         end
         else
            wdPhase_reg <= PH_LONG;
      end
      else if (wdFail)
      begin
         if (failure_count < failMax)
            failure_count <= failure_count + 2'h1;
         reset_out_n <= 1'b0;
         wdPhase_reg <= PH_OFF;
         msCnt_reg   <= 11'h000;
         opMode      <= failConfig[1] ? M_FAILSAFE : M_RESTART;
      end
      else
      begin
         // reset delay, shared by power-up, restart and soft reset
         if (!reset_out_n && (opMode == M_INIT || opMode == M_RESTART))
         begin
            if (msTick)
            begin
               if (msCnt_reg == RESET_DELAY_MS - 11'h001)
               begin
                  reset_out_n <= 1'b1;
                  msCnt_reg   <= 11'h000;
                  wdPhase_reg <= PH_LONG;
                  if (opMode == M_RESTART)
                     opMode <= M_NORMAL;
               end
               else
                  msCnt_reg <= msCnt_reg + 11'h001;
            end
         end
         else if (trigGood)
         begin
            msCnt_reg     <= 11'h000;
            failure_count <= 2'h0;
            if (inStop && wdPhase_reg == PH_OFF)
            begin
               wdPhase_reg                <= PH_LONG;
               stop_disable_enable_first  <= 1'b0;
               stop_disable_enable_second <= 1'b0;
            end
            else if (inNormal)
               wdPhase_reg <= pendData_reg[`WSR_CTRL_WIN_BIT] ?
                              PH_CLOSED : PH_OPEN;
            else
               wdPhase_reg <= window_type_select ? PH_CLOSED : PH_OPEN;
         end
         else if (wdRun & msTick)
         begin
            msCnt_reg <= msCnt_reg + 11'h001;
            if (wdPhase_reg == PH_CLOSED &&
                msCnt_reg == clsMs - 11'h001)
               wdPhase_reg <= PH_OPEN;
         end

         // configuration only moves in normal mode
         if (wrCtrl & parityOk & inNormal)
         begin
            window_type_select <= pendData_reg[`WSR_CTRL_WIN_BIT];
            period_select      <= pendData_reg[2:0];
            controlReadback    <= pendData_reg &
                                  ~(8'h01 << `WSR_CTRL_RSV_BIT);
            if (pendData_reg[`WSR_CTRL_EN1_BIT] &
                ~stop_disable_enable_first)
               stop_disable_enable_second <= 1'b0;
            else
               stop_disable_enable_second <=
                  pendData_reg[`WSR_CTRL_EN1_BIT];
         end

         // first enable of the stop disable sequence
         if (wrWake & inNormal)
         begin
            if (pendData_reg[`WSR_WAKE_EN0_BIT])
               stop_disable_enable_first <=
                  ~stop_disable_enable_first;
            else
               stop_disable_enable_first <= 1'b0;
         end

         // mode changes other than soft reset
         if (wrMode)
         begin
            if (inNormal)
               soft_reset_output_select <=
                  pendData_reg[`WSR_MODE_SRO_BIT];
            case (pendData_reg[1:0])
               `WSR_MODE_NORMAL:
                  if (opMode == M_INIT && reset_out_n)
                     opMode <= M_NORMAL;
                  else if (inStop)
                  begin
                     opMode                     <= M_NORMAL;
                     wdPhase_reg                <= PH_LONG;
                     msCnt_reg                  <= 11'h000;
                     stop_disable_enable_first  <= 1'b0;
                     stop_disable_enable_second <= 1'b0;
                  end
               `WSR_MODE_STOP:
                  if (inNormal)
                  begin
                     opMode <= M_STOP;
                     if (stop_disable_enable_first &
                         stop_disable_enable_second)
                     begin
                        wdPhase_reg   <= PH_OFF;
                        failure_count <= 2'h0;
                     end
                  end
               `WSR_MODE_SLEEP:
                  if (inNormal | inStop)
                  begin
                     opMode        <= M_SLEEP;
                     wdPhase_reg   <= PH_OFF;
                     failure_count <= 2'h0;
                  end
               default:
                  opMode <= opMode;
            endcase
         end

         // wake leaves sleep or fail-safe through restart
         if (wakeRequest &&
             (opMode == M_SLEEP || opMode == M_FAILSAFE))
         begin
            opMode      <= M_RESTART;
            reset_out_n <= 1'b0;
            msCnt_reg   <= 11'h000;
            wdPhase_reg <= PH_OFF;
         end
      end
   end

   // -------------------------------------------------------------
   // watchdog off indication, registered like every output
   // -------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         watchdogOff <= 1'b1;
      else
         watchdogOff <= ~wdRun;
   end

endmodule

// ===== testbench/wsr_host_model.sv
// host model: chip select pin and decoded write strobes of the spi side
// assumes the supervisor samples all of these on rising sys_clk edges
`timescale 1ns/1ns
module wsr_host_model (
   input  wire       sys_clk,
   output reg        csLow,
   output reg        wrStb,
   output reg  [1:0] wrAddr,
   output reg  [7:0] wrData
);
   // ----------------------------------------------------------
   // idle levels
   // ----------------------------------------------------------
   initial
   begin
      csLow = 1'b1;
      wrStb = 1'b0;
      wrAddr = 2'h0;
      wrData = 8'h00;
   end

   // one write per frame; data inverted once released so no stale match
   // chip select stays low three edges; the pin filter only drops a low held for under two
   task send(input [1:0] a, input [7:0] d);
   begin
      @(posedge sys_clk);
      #1;
      csLow = 1'b0;
      wrStb = 1'b1;
      wrAddr = a;
      wrData = d;
      @(posedge sys_clk);
      #1;
      wrStb = 1'b0;
      wrData = ~d;
      repeat (2) @(posedge sys_clk);
      #1;
      csLow = 1'b1;
      repeat (6) @(posedge sys_clk);
      #2;
   end
   endtask

   // checksum bit makes the whole byte even, reserved bit included
   task trig(input [6:0] v);
   begin
      send(2'h2, {^v, v});
   end
   endtask
endmodule

// ===== testbench/wsr_watchdog_asserts.sv
// checker: relations between the supervisor's ports over time
// assumes a bind onto wsr_watchdog, single sys_clk domain
`timescale 1ns/1ns
module wsr_watchdog_asserts (
   input wire       sys_clk,
   input wire       rst_n,
   input wire       devStrap,
   input wire [1:0] failConfig,
   input wire       reset_out_n,
   input wire [2:0] opMode,
   input wire [1:0] failure_count,
   input wire [2:0] period_select,
   input wire       window_type_select,
   input wire       soft_reset_output_select,
   input wire       stop_disable_enable_first,
   input wire       stop_disable_enable_second,
   input wire [7:0] controlReadback
);
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_reset_low_hold: assert property (
      $fell(reset_out_n) |=> !reset_out_n [*8])
      else $error("reset output pulse too short");
   a_count_step: assert property (
      $changed(failure_count) && failure_count != 2'h0
      |-> failure_count == $past(failure_count) + 2'h1)
      else $error("failure count jumped");
   a_count_limit: assert property (
      failure_count != 2'h3 &&
      (failConfig != 2'h1 || failure_count != 2'h2))
      else $error("failure count past its ceiling");
   a_fail_resets: assert property (
      failure_count > $past(failure_count) |-> ##[0:3] !reset_out_n)
      else $error("failure without reset output");
   a_dev_quiet: assert property (
      devStrap [*5] |-> failure_count <= $past(failure_count))
      else $error("failure counted in development mode");
   a_cfg_normal_only: assert property (
      $changed(period_select) || $changed(window_type_select)
      |-> $past(opMode) == 3'h1 || opMode == 3'h0)
      else $error("watchdog setting changed outside normal");
   a_soft_defaults: assert property (
      ($past(opMode) == 3'h1 || $past(opMode) == 3'h2) && opMode == 3'h0
      |-> period_select == 3'h4 && !window_type_select &&
      !soft_reset_output_select && !stop_disable_enable_first &&
      !stop_disable_enable_second)
      else $error("soft reset left settings");
   a_soft_keep_ro: assert property (
      $past(opMode) == 3'h1 && opMode == 3'h0 &&
      $past(soft_reset_output_select) |-> reset_out_n [*4])
      else $error("reset output pulsed though deselected");
   a_rsv_reads_zero: assert property (
      controlReadback[3] == 1'b0)
      else $error("reserved bit reads back set");
   a_stop_exit_clear: assert property (
      $past(opMode) == 3'h2 && opMode == 3'h1
      |-> !stop_disable_enable_first && !stop_disable_enable_second)
      else $error("stop enables kept on return to normal");
endmodule

// ===== testbench/wsr_watchdog_test.sv
// testbench: watchdog and soft reset supervisor, one ms tick = 10 clocks
// assumes wsr_host_model drives chip select and writes
`timescale 1ns/1ns
module wsr_watchdog_test;
   reg         sys_clk;
   reg         rst_n;
   reg         devStrap;
   reg  [1:0]  failConfig;
   reg         wakeRequest;
   reg         spiFailClear;
   wire        csLow;
   wire        wrStb;
   wire [1:0]  wrAddr;
   wire [7:0]  wrData;
   wire        roN;
   wire [2:0]  opMode;
   wire [1:0]  failCnt;
   wire        spiFail;
   wire        winSel;
   wire [2:0]  perSel;
   wire        sro;
   wire        en0;
   wire        en1;
   wire        wdOff;
   wire [7:0]  readback;
   integer     err_total;
   integer     check_count;
   integer     cyc;
   integer     s;

   // short tick keeps the 1000 ms period within about ten thousand clocks
   wsr_watchdog #(.TICK_CYCLES(24'd10)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .chip_select_low_active(csLow),
      .devStrap(devStrap), .cmdWrite(wrStb), .cmdAddr(wrAddr),
      .cmdData(wrData), .failConfig(failConfig),
      .wakeRequest(wakeRequest), .spiFailClear(spiFailClear),
      .reset_out_n(roN), .opMode(opMode), .failure_count(failCnt),
      .spiFail(spiFail), .window_type_select(winSel),
      .period_select(perSel), .soft_reset_output_select(sro),
      .stop_disable_enable_first(en0), .stop_disable_enable_second(en1),
      .watchdogOff(wdOff), .controlReadback(readback));
   wsr_host_model host (.sys_clk(sys_clk), .csLow(csLow), .wrStb(wrStb),
      .wrAddr(wrAddr), .wrData(wrData));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task chk(input [31:0] got, input [31:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask

   task chk_rng(input [31:0] got, input [31:0] lo, input [31:0] hi);
   begin
      check_count = check_count + 1;
      if (got < lo || got > hi)
      begin
         err_total = err_total + 1;
         $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   end
   endtask

   task tick(input integer n);
   begin
      repeat (n) @(posedge sys_clk);
      #1;
   end
   endtask

   // bounded wait for a reset output level, cycles waited in cyc
   task wait_ro(input v, input integer lim);
   begin
      cyc = 0;
      while (roN !== v && cyc < lim)
      begin
         @(negedge sys_clk);
         cyc = cyc + 1;
      end
   end
   endtask

   task do_reset(input strap);
   begin
      tick(1);
      devStrap = strap;
      rst_n = 1'b0;
      tick(16);
      rst_n = 1'b1;
      wait_ro(1'b1, 300);
      chk_rng(cyc, 95, 115);
   end
   endtask

   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask

   function integer ms(input integer sel);
   begin
      case (sel)
         1: ms = 10;
         2: ms = 20;
         3: ms = 50;
         4: ms = 100;
         5: ms = 200;
         6: ms = 500;
         default: ms = 1000;
      endcase
   end
   endfunction

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task t_defaults_parity;
   begin
      chk({opMode, perSel, winSel, failCnt}, {3'h0, 3'h4, 1'b0, 2'h0});
      chk(readback, 8'h04);
      host.send(2'h0, 8'h00);
      host.send(2'h2, 8'h0B); // parity counts the reserved bit, so this byte is odd
      chk({spiFail, perSel}, {1'b1, 3'h4});
      host.send(2'h2, 8'h8B);
      chk({perSel, readback}, {3'h3, 8'h83});
      tick(1);
      spiFailClear = 1'b1;
      tick(1);
      spiFailClear = 1'b0;
      tick(3);
      chk(spiFail, 1'b0);
   end
   endtask

   // period settings 1 to 7 each expire untriggered, one failure each time
   task t_periods;
   begin
      for (s = 1; s <= 7; s = s + 1)
      begin
         wait_ro(1'b1, 300);
         tick(4);
         host.trig(s[6:0]);
         wait_ro(1'b0, 10100);
         chk_rng(cyc, ms(s) * 10 - 12, ms(s) * 10 + 12);
         tick(2);
         chk({opMode, failCnt}, {3'h4, 2'h1});
      end
      wait_ro(1'b1, 300);
      tick(2);
      chk(opMode, 3'h1);
      wait_ro(1'b0, 2100);
      chk_rng(cyc, 1985, 2015);
      chk(failCnt, 2'h2);
      wait_ro(1'b1, 300);
      wait_ro(1'b0, 2100);
      chk(failCnt, 2'h2);
      tick(1);
      failConfig = 2'h2;
      wait_ro(1'b1, 300);
      wait_ro(1'b0, 2100);
      tick(2);
      chk(opMode, 3'h5);
      wakeRequest = 1'b1;
      tick(1);
      wakeRequest = 1'b0;
      failConfig = 2'h0;
      wait_ro(1'b1, 300);
      host.trig(7'h04);
      chk({opMode, failCnt}, {3'h1, 2'h0});
   end
   endtask

   // host triggers about 0.9 of the period apart, then hits the closed window
   task t_window;
   begin
      host.trig(7'h12);
      repeat (3)
      begin
         tick(170);
         host.trig(7'h12);
      end
      chk({roN, failCnt, winSel}, {1'b1, 2'h0, 1'b1});
      tick(50);
      host.trig(7'h12);
      wait_ro(1'b0, 30);
      chk_rng(cyc, 0, 5);
      chk(failCnt, 2'h1);
   end
   endtask

   task t_stop_soft;
   begin
      wait_ro(1'b1, 300);
      host.trig(7'h24);
      chk(en1, 1'b0);
      host.send(2'h1, 8'h01);
      host.send(2'h1, 8'h01);
      chk(en0, 1'b0);
      host.send(2'h1, 8'h01);
      host.trig(7'h24);
      chk({en0, en1}, 2'h3);
      host.send(2'h0, 8'h02);
      tick(2);
      chk({opMode, wdOff, failCnt}, {3'h2, 1'b1, 2'h0});
      tick(2500);
      chk(roN, 1'b1);
      host.trig(7'h01);
      chk({perSel, en0, en1, wdOff}, {3'h4, 3'h0});
      host.send(2'h0, 8'h04);
      host.trig(7'h11);
      host.send(2'h0, 8'h04); // output select only moves in normal
      chk({opMode, sro, perSel}, {3'h1, 1'b1, 3'h1});
      host.send(2'h0, 8'h07);
      chk({opMode, perSel, winSel}, {3'h0, 3'h4, 1'b0});
      wait_ro(1'b0, 150);
      chk(roN, 1'b1);
      host.send(2'h0, 8'h03);
      chk(opMode, 3'h0);
      host.send(2'h0, 8'h00);
      host.send(2'h0, 8'h03);
      wait_ro(1'b0, 10);
      chk({roN, opMode, sro}, {1'b0, 3'h0, 1'b0});
      wait_ro(1'b1, 200);
      chk_rng(cyc, 85, 115);
   end
   endtask

   task t_dev_cfg2;
   begin
      do_reset(1'b1);
      host.send(2'h0, 8'h00);
      tick(4500);
      chk({roN, failCnt}, {1'b1, 2'h0});
      failConfig = 2'h1;
      do_reset(1'b0);
      wait_ro(1'b0, 2100);
      chk(failCnt, 2'h1);
      wait_ro(1'b1, 300);
      wait_ro(1'b0, 2100);
      chk(failCnt, 2'h1);
   end
   endtask

   // ----------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------
   initial
   begin
      err_total = 0;
      check_count = 0;
      rst_n = 1'b0;
      devStrap = 1'b0;
      failConfig = 2'h0;
      wakeRequest = 1'b0;
      spiFailClear = 1'b0;
      do_reset(1'b0);
      t_defaults_parity;
      t_periods;
      t_window;
      t_stop_soft;
      t_dev_cfg2;
      wrap_up;
   end

   initial
   begin
      #900000;
      err_total = err_total + 1;
      wrap_up;
   end
endmodule

bind wsr_watchdog wsr_watchdog_asserts wdChecker (.sys_clk(sys_clk),
   .rst_n(rst_n), .devStrap(devStrap), .failConfig(failConfig),
   .reset_out_n(reset_out_n), .opMode(opMode),
   .failure_count(failure_count), .period_select(period_select),
   .window_type_select(window_type_select),
   .soft_reset_output_select(soft_reset_output_select),
   .stop_disable_enable_first(stop_disable_enable_first),
   .stop_disable_enable_second(stop_disable_enable_second),
   .controlReadback(controlReadback));
